/* File: hw/tws_core.sv */
// Three-wire serial interface with an AXI4-Lite register slave
`timescale 1ns/1ps
`default_nettype none

module tws_core (
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    input  wire logic [tws_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    input  wire logic [31:0]                s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    output logic [1:0]                      s_axi_bresp,
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    input  wire logic [tws_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    output logic [31:0]                     s_axi_rdata,
    output logic [1:0]                      s_axi_rresp,
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready,
    input  wire logic                       sck_in,
    output logic                            sck_out,
    output logic                            sck_oe,
    input  wire logic                       si_in,
    output logic                            so_out
);

    //------------------------------------------------------------------
    // Helpers
    //------------------------------------------------------------------
    // Word index of a byte address; low two bits ignored
    function automatic logic [15:0] reg_idx(
        input logic [tws_pkg::ADDR_W-1:0] a);
        reg_idx = a[tws_pkg::ADDR_W-1:2];
    endfunction : reg_idx

    function automatic logic reg_hit(input logic [15:0] i);
        reg_hit = (i == tws_pkg::IDX_MODE) || (i == tws_pkg::IDX_CLKSEL)
               || (i == tws_pkg::IDX_TXBUF) || (i == tws_pkg::IDX_SHIFT);
    endfunction : reg_hit

    // Bit presented on the output line for a given order
    function automatic logic out_bit(input logic [7:0] d,
                                     input logic       lsb_first);
        out_bit = lsb_first ? d[0] : d[7];
    endfunction : out_bit

    function automatic logic [7:0] shift_in(input logic [7:0] d,
                                            input logic       lsb_first,
                                            input logic       b);
        shift_in = lsb_first ? {b, d[7:1]} : {d[6:0], b};
    endfunction : shift_in

    tws_pkg::tws_state_t s_reg;
    tws_pkg::tws_state_t s_next;

    logic        master;
    logic [6:0]  div_lim;
    logic        edge_ev;
    logic        lead;
    logic        out_ev;
    logic        smp_ev;
    logic        commit;
    logic        ar_take;
    logic [15:0] ar_idx;

    //------------------------------------------------------------------
    // Serial clock events
    //------------------------------------------------------------------
    // Half period is 2^cks clocks, so the line runs at clk/2^(cks+1)
    assign master  = (s_reg.cks != tws_pkg::CKS_SLAVE);
    assign div_lim = 7'(7'h01 << s_reg.cks) - 7'h01;
    // Slave counts every toggle of the external clock
    assign edge_ev = s_reg.busy && (master ? (s_reg.div == div_lim)
                                           : (sck_in != s_reg.sck_prev));
    // Even edges leave the idle level, odd edges return to it
    assign lead    = ~s_reg.edges[0];
    assign out_ev  = edge_ev && (s_reg.dap ? !lead : lead);
    assign smp_ev  = edge_ev && (s_reg.dap ? lead : !lead);

    // Bus handshakes
    assign commit  = s_reg.aw_have && s_reg.w_have && !s_reg.bvalid;
    assign ar_take = s_axi_arvalid && s_axi_arready;
    assign ar_idx  = reg_idx(s_axi_araddr);

    //------------------------------------------------------------------
    // Next state
    //------------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        s_next.sck_prev = sck_in;

        // Serial engine
        if (s_reg.busy) begin
            if (master) begin
                s_next.div = edge_ev ? 7'h00 : s_reg.div + 7'h01;
            end
            if (edge_ev) begin
                s_next.edges = s_reg.edges + 5'h01;
                if (master) begin
                    s_next.sck = ~s_reg.sck;
                end
                // Skip the closing trail edge in phase-shifted timing
                if (out_ev && s_reg.edges != tws_pkg::LAST_EDGE) begin
                    s_next.so = out_bit(s_reg.shr, s_reg.dir);
                end
                if (smp_ev) begin
                    // Same register shifts out and in together
                    s_next.shr = shift_in(s_reg.shr, s_reg.dir,
                                          si_in);
                end
                if (s_reg.edges == tws_pkg::LAST_EDGE) begin
                    s_next.busy = 1'b0;
                end
            end
        end else begin
            s_next.sck = ~s_reg.ckp;
        end

        // Write channel acceptance
        if (s_axi_awvalid && s_axi_awready) begin
            s_next.aw_have = 1'b1;
            s_next.aw_idx  = reg_idx(s_axi_awaddr);
        end
        if (s_axi_wvalid && s_axi_wready) begin
            s_next.w_have = 1'b1;
            s_next.wbyte  = s_axi_wdata[7:0];
            s_next.wlane  = s_axi_wstrb[0];
        end
        if (s_reg.bvalid && s_axi_bready) begin
            s_next.bvalid = 1'b0;
        end

        // Register write, one cycle after both halves are held
        if (commit) begin
            s_next.aw_have = 1'b0;
            s_next.w_have  = 1'b0;
            s_next.bvalid  = 1'b1;
            s_next.bresp   = reg_hit(s_reg.aw_idx) ? tws_pkg::RESP_OKAY
                                                   : tws_pkg::RESP_SLVERR;
            if (s_reg.wlane) begin
                unique case (s_reg.aw_idx)
                    tws_pkg::IDX_MODE: begin
                        s_next.en   = s_reg.wbyte[tws_pkg::MODE_EN_BIT];
                        s_next.trmd = s_reg.wbyte[tws_pkg::MODE_TRMD_BIT];
                        s_next.dir  = s_reg.wbyte[tws_pkg::MODE_DIR_BIT];
                    end
                    tws_pkg::IDX_CLKSEL: begin
                        s_next.ckp = s_reg.wbyte[tws_pkg::CLK_CKP_BIT];
                        s_next.dap = s_reg.wbyte[tws_pkg::CLK_DAP_BIT];
                        s_next.cks = s_reg.wbyte[tws_pkg::CLK_CKS_LSB +: 3];
                        if (!s_reg.busy) begin
                            s_next.sck =
                                ~s_reg.wbyte[tws_pkg::CLK_CKP_BIT];
                        end
                    end
                    tws_pkg::IDX_TXBUF: begin
                        s_next.txb = s_reg.wbyte;
                        // A write during a transfer does not restart it
                        if (s_reg.en && s_reg.trmd && !s_reg.busy) begin
                            s_next.shr   = s_reg.wbyte;
                            s_next.busy  = 1'b1;
                            s_next.edges = 5'h00;
                            s_next.div   = 7'h00;
                            if (s_reg.dap) begin
                                s_next.so = out_bit(s_reg.wbyte,
                                                    s_reg.dir);
                            end
                        end
                    end
                    default: ;
                endcase
            end
        end

        // Read channel
        if (s_reg.rvalid && s_axi_rready) begin
            s_next.rvalid = 1'b0;
        end
        if (ar_take) begin
            s_next.rvalid = 1'b1;
            s_next.rresp  = reg_hit(ar_idx) ? tws_pkg::RESP_OKAY
                                            : tws_pkg::RESP_SLVERR;
            s_next.rdata  = 32'h0000_0000;
            unique case (ar_idx)
                tws_pkg::IDX_MODE: begin
                    s_next.rdata[tws_pkg::MODE_EN_BIT]   = s_reg.en;
                    s_next.rdata[tws_pkg::MODE_TRMD_BIT] = s_reg.trmd;
                    s_next.rdata[tws_pkg::MODE_DIR_BIT]  = s_reg.dir;
                    s_next.rdata[tws_pkg::MODE_BUSY_BIT] =
                        s_reg.busy;
                end
                tws_pkg::IDX_CLKSEL: begin
                    s_next.rdata[tws_pkg::CLK_CKP_BIT] = s_reg.ckp;
                    s_next.rdata[tws_pkg::CLK_DAP_BIT] = s_reg.dap;
                    s_next.rdata[tws_pkg::CLK_CKS_LSB +: 3] = s_reg.cks;
                end
                tws_pkg::IDX_TXBUF: s_next.rdata[7:0] = s_reg.txb;
                tws_pkg::IDX_SHIFT: begin
                    s_next.rdata[7:0] = s_reg.shr;
                    // Receive-only transfer starts on reading the byte
                    if (s_reg.en && !s_reg.trmd && !s_reg.busy
                        && !commit) begin
                        s_next.busy  = 1'b1;
                        s_next.edges = 5'h00;
                        s_next.div   = 7'h00;
                    end
                end
                default: ;
            endcase
        end

        // Disabled interface holds the engine cleared
        if (!s_next.en) begin
            s_next.busy  = 1'b0;
            s_next.shr   = tws_pkg::RST_SHIFT;
            s_next.edges = 5'h00;
            s_next.div   = 7'h00;
            s_next.so    = 1'b0;
            s_next.sck   = ~s_next.ckp;
        end

        // Receive-only mode keeps the output flop low, so no gating
        if (!s_next.trmd) begin
            s_next.so = 1'b0;
        end
    end

    //------------------------------------------------------------------
    // State register
    //------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg       <= '0;
            s_reg.txb   <= tws_pkg::RST_TXBUF;
            s_reg.shr   <= tws_pkg::RST_SHIFT;
            s_reg.sck   <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    //------------------------------------------------------------------
    // Outputs
    //------------------------------------------------------------------
    // One transaction per channel keeps the slave simple
    assign s_axi_awready = !s_reg.aw_have && !s_reg.bvalid;
    assign s_axi_wready  = !s_reg.w_have && !s_reg.bvalid;
    assign s_axi_bvalid  = s_reg.bvalid;
    assign s_axi_bresp   = s_reg.bresp;
    assign s_axi_arready = !s_reg.rvalid;
    assign s_axi_rvalid  = s_reg.rvalid;
    assign s_axi_rdata   = s_reg.rdata;
    assign s_axi_rresp   = s_reg.rresp;
    assign sck_out       = s_reg.sck;
    assign sck_oe        = s_reg.en && master;
    assign so_out        = s_reg.so;

    //------------------------------------------------------------------
    // Assertions
    //------------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_so_low;
        !s_reg.trmd |-> !so_out;
    endproperty
    a_so_low: assert property (p_so_low)
        else $error("output not low in receive mode");

    property p_tx_start;
        commit && s_reg.wlane && s_reg.aw_idx == tws_pkg::IDX_TXBUF
        && s_reg.en && s_reg.trmd && !s_reg.busy
        |=> s_reg.busy && s_reg.shr == $past(s_reg.wbyte);
    endproperty
    a_tx_start: assert property (p_tx_start)
        else $error("buffer write did not start transfer");

    property p_rx_start;
        ar_take && ar_idx == tws_pkg::IDX_SHIFT && s_reg.en
        && !s_reg.trmd && !s_reg.busy && !commit |=> s_reg.busy;
    endproperty
    a_rx_start: assert property (p_rx_start)
        else $error("shifter read did not start receive");

    property p_disable;
        $fell(s_reg.en) |-> !s_reg.busy && s_reg.shr == 8'h00;
    endproperty
    a_disable: assert property (p_disable)
        else $error("disable left flag or shifter set");

    property p_length;
        $rose(s_reg.busy) && s_reg.cks == 3'h0 && s_reg.en
        |-> ##15 s_reg.busy ##1 !s_reg.busy;
    endproperty
    a_length: assert property (p_length)
        else $error("fast transfer not sixteen half clocks");

    property p_idle;
        !s_reg.busy && s_reg.en && master |-> sck_out == !s_reg.ckp;
    endproperty
    a_idle: assert property (p_idle)
        else $error("serial clock not at idle level");

    property p_div;
        $rose(s_reg.busy) && s_reg.cks == 3'h1 && s_reg.en
        |-> ##1 $stable(s_reg.sck) ##1 $changed(s_reg.sck);
    endproperty
    a_div: assert property (p_div)
        else $error("divide by four edge misplaced");

    property p_msb;
        smp_ev && !s_reg.dir && s_next.en |=> s_reg.shr[0] == $past(si_in);
    endproperty
    a_msb: assert property (p_msb)
        else $error("MSB-first sample not in bit 0");

    property p_lsb;
        smp_ev && s_reg.dir && s_next.en |=> s_reg.shr[7] == $past(si_in);
    endproperty
    a_lsb: assert property (p_lsb)
        else $error("LSB-first sample not in bit 7");

    property p_flag;
        ar_take && ar_idx == tws_pkg::IDX_MODE
        |=> s_axi_rdata[0] == $past(s_reg.busy);
    endproperty
    a_flag: assert property (p_flag)
        else $error("busy flag read wrong");

    c_tx: cover property ($fell(s_reg.busy) && s_reg.trmd);
    c_rx: cover property ($fell(s_reg.busy) && !s_reg.trmd);
    c_slave: cover property ($fell(s_reg.busy) && !master);
    c_err: cover property (s_axi_rvalid && s_axi_rresp != 2'h0);

endmodule : tws_core

`default_nettype wire

/* File: hw/tws_pkg.sv */
// Constants and state types of the three-wire serial interface
package tws_pkg;

    //------------------------------------------------------------------
    // Register indices (byte address = 4 * index)
    //------------------------------------------------------------------
    localparam int           ADDR_W       = 18;
    localparam logic [15:0]  IDX_MODE     = 16'hFF80;
    localparam logic [15:0]  IDX_CLKSEL   = 16'hFF81;
    localparam logic [15:0]  IDX_TXBUF    = 16'hFF82;
    localparam logic [15:0]  IDX_SHIFT    = 16'hFF83;

    //------------------------------------------------------------------
    // Field positions
    //------------------------------------------------------------------
    localparam int           MODE_EN_BIT   = 7;
    localparam int           MODE_TRMD_BIT = 6;
    localparam int           MODE_DIR_BIT  = 4;
    localparam int           MODE_BUSY_BIT = 0;
    localparam int           CLK_CKP_BIT   = 4;
    localparam int           CLK_DAP_BIT   = 3;
    localparam int           CLK_CKS_LSB   = 0;
    localparam logic [2:0]   CKS_SLAVE     = 3'h7;

    //------------------------------------------------------------------
    // Reset values and timing counts
    //------------------------------------------------------------------
    localparam logic [7:0]   RST_MODE      = 8'h00;
    localparam logic [7:0]   RST_CLKSEL    = 8'h00;
    localparam logic [7:0]   RST_TXBUF     = 8'h00;
    localparam logic [7:0]   RST_SHIFT     = 8'h00;
    localparam logic [4:0]   LAST_EDGE     = 5'h0F;
    localparam logic [1:0]   RESP_OKAY     = 2'h0;
    localparam logic [1:0]   RESP_SLVERR   = 2'h2;

    //------------------------------------------------------------------
    // Whole state of the block
    //------------------------------------------------------------------
    typedef struct packed {
        logic        en;
        logic        trmd;
        logic        dir;
        logic        ckp;
        logic        dap;
        logic [2:0]  cks;
        logic [7:0]  txb;
        logic [7:0]  shr;
        logic        busy;
        logic [4:0]  edges;
        logic [6:0]  div;
        logic        sck;
        logic        so;
        logic        sck_prev;
        logic        aw_have;
        logic        w_have;
        logic [15:0] aw_idx;
        logic [7:0]  wbyte;
        logic        wlane;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
    } tws_state_t;

endpackage : tws_pkg

/* File: tb/tb_three_wire_serial_io.sv */
// Self-checking bench for the three-wire serial interface
`timescale 1ns/1ps
`default_nettype none

module tb_three_wire_serial_io;
    localparam logic [17:0] A_MODE = {tws_pkg::IDX_MODE, 2'b00};
    localparam logic [17:0] A_CLK  = {tws_pkg::IDX_CLKSEL, 2'b00};
    localparam logic [17:0] A_TXB  = {tws_pkg::IDX_TXBUF, 2'b00};
    localparam logic [17:0] A_SHR  = {tws_pkg::IDX_SHIFT, 2'b00};

    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [17:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata, rdv;
    logic [3:0]  wstrb = '0;
    logic        awvalid = '0, wvalid = '0, bready = '0;
    logic        arvalid = '0, rready = '0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, rrv, brv;
    logic        sck_out, sck_oe, so_out, sck_line, sck_gen, si;
    logic        arm = '0, gen = '0, ckp = '0, dap = '0, lsb = '0;
    logic        rx_only = '0, so_bad = '0, last = '0;
    logic [7:0]  ptx = '0, prx;
    logic [17:0] amap [4] = '{A_MODE, A_CLK, A_TXB, A_SHR};
    int          fails = 0, total_checks = 0;
    int          edges = 0, gap = 0, run = 0, e0;

    always #2 aclk = ~aclk;
    assign sck_line = sck_oe ? sck_out : sck_gen;

    tws_core dut_u (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sck_in(sck_line),
        .sck_out(sck_out), .sck_oe(sck_oe), .si_in(si), .so_out(so_out));

    tws_peer peer_u (.aclk(aclk), .arm(arm), .gen(gen), .ckp(ckp),
        .dap(dap), .lsb(lsb), .tx_byte(ptx), .sck_line(sck_line),
        .so(so_out), .sck_gen(sck_gen), .si(si), .rx_byte(prx));

    // Edge counter, half-period meter and output-low watch
    always @(posedge aclk) begin
        last <= sck_out;
        run <= (sck_out !== last) ? 1 : run + 1;
        if (sck_out !== last) begin
            edges <= edges + 1;
            gap <= run;
        end
        if (rx_only && so_out !== 1'b0) so_bad <= 1'b1;
    end

    task automatic chk(input string nm, input logic [31:0] s,
                       input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : conclude

    // Write: both halves offered together, each dropped when taken
    task automatic wr(input logic [17:0] a, input logic [7:0] d);
        logic aw;
        logic w;
        aw = 1'b0;
        w = 1'b0;
        awaddr <= a;
        wdata <= {24'h000000, d};
        wstrb <= 4'h1;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (!aw && awready === 1'b1) begin
                aw = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w && wready === 1'b1) begin
                w = 1'b1;
                wvalid <= 1'b0;
            end
        end while (!(aw && w && bvalid === 1'b1));
        brv = bresp;
    endtask : wr

    task automatic rd(input logic [17:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rdv = rdata;
        rrv = rresp;
    endtask : rd

    // Only the status register is touched while busy
    task automatic wait_idle();
        do rd(A_MODE); while (rdv[0] !== 1'b0);
    endtask : wait_idle

    task automatic setup(input logic [7:0] m, input logic [7:0] c);
        wr(A_MODE, 8'h00);
        wr(A_CLK, c);
        wr(A_MODE, m);
        ckp <= c[4];
        dap <= c[3];
        lsb <= m[4];
    endtask : setup

    task automatic start_peer(input logic [7:0] p);
        ptx <= p;
        arm <= 1'b1;
        @(posedge aclk);
        arm <= 1'b0;
    endtask : start_peer

    task automatic xfer(input logic [7:0] t, input logic [7:0] p);
        start_peer(p);
        wr(A_TXB, t);
        gen <= ~sck_oe;
        wait_idle();
        gen <= 1'b0;
    endtask : xfer

    // Main sequence
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int i = 0; i < 4; i++) begin
            rd(amap[i]);
            chk("reset value", rdv, 32'h0);
        end
        chk("sck idle", sck_out, 1'b1);
        rd(18'h00010);
        chk("unmapped resp", rrv, tws_pkg::RESP_SLVERR);
        wr(18'h00010, 8'h00);
        chk("unmapped wr resp", brv, tws_pkg::RESP_SLVERR);
        wr(A_MODE, 8'h01);
        rd(A_MODE);
        chk("busy read only", rdv, 32'h0);
        wr(A_TXB, 8'h5A);
        chk("buffer wr resp", brv, tws_pkg::RESP_OKAY);
        rd(A_MODE);
        chk("no start when off", rdv, 32'h0);
        rd(A_TXB);
        chk("buffer rw", rdv, 32'h5A);
        $display("test reset_map done");
        for (int c = 0; c < 7; c++) begin
            setup(8'hC0, c[7:0]);
            chk("master oe", sck_oe, 1'b1);
            e0 = edges;
            xfer(8'hA5, 8'h3C);
            chk("edge count", edges - e0, 16);
            chk("half period", gap, 1 << c);
            chk("peer rx", prx, 8'hA5);
        end
        $display("test dividers done");
        for (int t = 0; t < 8; t++) begin
            setup({3'h6, t[2], 4'h0}, {3'h0, t[1:0], 3'h1});
            chk("sck idle", sck_out, !t[1]);
            xfer(8'h4B ^ t[7:0], 8'hD1);
            chk("peer rx", prx, 8'h4B ^ t[7:0]);
            rd(A_SHR);
            chk("device rx", rdv, 32'hD1);
        end
        $display("test timing_types done");
        for (int t = 0; t < 2; t++) begin
            setup({3'h4, t[0], 4'h0}, 8'h02);
            start_peer(8'h6E);
            rx_only <= 1'b1;
            rd(A_SHR);
            wait_idle();
            rx_only <= 1'b0;
            rd(A_SHR);
            chk("rx only", rdv, 32'h6E);
            chk("so held low", so_bad, 1'b0);
            // The read above starts another reception; let it end
            wait_idle();
        end
        $display("test receive_only done");
        setup(8'hC0, 8'h07);
        chk("slave oe", sck_oe, 1'b0);
        xfer(8'h29, 8'h94);
        chk("slave peer rx", prx, 8'h29);
        rd(A_SHR);
        chk("slave rx", rdv, 32'h94);
        $display("test slave done");
        setup(8'hC0, 8'h06);
        start_peer(8'hFF);
        wr(A_TXB, 8'h00);
        repeat (300) @(posedge aclk);
        rd(A_MODE);
        chk("busy flag", rdv, 32'hC1);
        wr(A_MODE, 8'h40);
        rd(A_MODE);
        chk("busy cleared", rdv, 32'h40);
        rd(A_SHR);
        chk("shift cleared", rdv, 32'h0);
        $display("test disable done");
        conclude();
    end

    // Watchdog against a hung handshake
    initial begin
        repeat (40000) @(posedge aclk);
        fails++;
        conclude();
    end
endmodule : tb_three_wire_serial_io

`default_nettype wire

/* File: tb/tws_peer.sv */
// Model of the peripheral device on the far side of the serial link
`timescale 1ns/1ps
`default_nettype none

module tws_peer (
    input  wire logic       aclk,
    input  wire logic       arm,
    input  wire logic       gen,
    input  wire logic       ckp,
    input  wire logic       dap,
    input  wire logic       lsb,
    input  wire logic [7:0] tx_byte,
    input  wire logic       sck_line,
    input  wire logic       so,
    output logic            sck_gen,
    output logic            si,
    output logic [7:0]      rx_byte
);
    logic [4:0] cnt;
    logic [4:0] tg;
    logic [1:0] hp;
    logic       prev;

    // Bit position in transfer order
    function automatic logic [2:0] slot(input logic [2:0] i);
        return lsb ? i : 3'h7 - i;
    endfunction : slot

    // Known levels before the first frame
    initial begin
        sck_gen = 1'b1;
        si = 1'b0;
        cnt = 5'h00;
        tg = 5'h10;
        hp = 2'h0;
        prev = 1'b1;
    end

    // Slave clock: sixteen edges, then stands at idle
    always @(posedge aclk) begin
        if (arm) begin
            tg <= 5'h00;
            hp <= 2'h0;
            sck_gen <= ~ckp;
        end else if (gen && tg < 5'h10) begin
            hp <= hp + 2'h1;
            if (hp == 2'h3) begin
                sck_gen <= ~sck_gen;
                tg <= tg + 5'h01;
            end
        end
    end

    // Drive on one edge, sample on the other; eight bits a frame
    always @(posedge aclk) begin
        if (arm) begin
            cnt <= 5'h00;
            prev <= ~ckp;
            si <= dap ? tx_byte[slot(3'h0)] : ~si;
        end else if (sck_line !== prev) begin
            prev <= sck_line;
            cnt <= cnt + 5'h01;
            if (cnt[0] != dap) rx_byte[slot(cnt[3:1])] <= so;
            else if (!dap) si <= tx_byte[slot(cnt[3:1])];
            else if (cnt != 5'h0F) si <= tx_byte[slot(cnt[3:1] + 3'h1)];
            // Released line flips so a stale bit cannot pass
            if (cnt == 5'h0F) si <= ~si;
        end
    end
endmodule : tws_peer

`default_nettype wire
